//--- src/vout_prot_params.svh
// Constants for the output-voltage protection block: codes, fields, bounds.
// Included by the design module and the testbench; definitions only.
`ifndef VOUT_PROT_PARAMS_SVH
`define VOUT_PROT_PARAMS_SVH

// Command codes
`define CMD_OV_FAULT_ACTION 8'h41
`define CMD_HIGH_WARN 8'h42
`define CMD_LOW_WARN 8'h43

// Fault action byte fields
`define ACT_SEL_HI 7
`define ACT_SEL_LO 6
`define ACT_RETRY_HI 5
`define ACT_RETRY_LO 3
`define ACT_MULT_HI 2
`define ACT_MULT_LO 0
`define ACT_IGNORE 2'h0
`define ACT_INVALID 2'h3
`define RETRY_LATCH 3'h0
`define RETRY_ENDLESS 3'h7

// Reset values before the stored copy is loaded
`define RST_FAULT_ACTION 8'h80
`define RST_HIGH_WARN 16'h0213
`define RST_LOW_WARN 16'h01D7

// Relative format: value / REL_DEN is the ratio to the target
`define REL_DEN 32'h0000_0200

// Supported percentages
`define HIGH_PCT_MIN 8'h67
`define HIGH_PCT_MAX 8'h74
`define LOW_PCT_MIN 8'h54
`define LOW_PCT_MAX 8'h61
`define FAULT_PCT10_MIN 11'h41A
`define FAULT_PCT10_MAX 11'h578
`define FAULT_PCT10_STEP 32'h0000_0019

// Start-up timeout figure that means disabled, in clk cycles as ton_max_cycles
`define TON_MAX_DISABLED_MS 24'h00_0000

// Status bit positions
`define SV_OV_FAULT 7
`define SV_OV_WARN 6
`define SV_UV_WARN 5
`define CML_BAD_CMD 7
`define CML_BAD_DATA 6

`endif

//--- src/vout_prot_pkg.sv
// Types for the output-voltage protection block.
// Assumes vout_prot_params.svh on the include path.
package vout_prot_pkg;

  // Decoded command transaction from the bus front end
  typedef struct packed {
    logic write;
    logic is_word;
    logic [7:0] code;
    logic [15:0] data;
  } link_req_t;

  // Answer to one transaction
  typedef struct packed {
    logic error;
    logic [15:0] data;
  } link_rsp_t;

  // Restart sequencer, Gray along off-ramp-confirm-run-hiccup-latched
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_RAMP = 3'h1,
    ST_CONFIRM = 3'h3,
    ST_RUN = 3'h2,
    ST_HICCUP = 3'h6,
    ST_LATCHED = 3'h7
  } seq_state_t;

endpackage

//--- src/sync2.sv
// Two-flop synchroniser for levels and toggles.
// Assumes the input changes no faster than the destination clock can see.
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] dout_d;

  always_comb begin
    meta_d = din;
    dout_d = meta_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= meta_d;
      dout <= dout_d;
    end
  end
endmodule

//--- src/link_port.sv
// Link-clock side of the command port: takes a transaction, hands it over.
// Assumes the core returns an ack toggle only after req_tog changed.
`timescale 1ns/10ps
module link_port (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire vout_prot_pkg::link_req_t req_in,
  output logic req_ready,
  output logic rsp_valid,
  output vout_prot_pkg::link_rsp_t rsp_out,
  output vout_prot_pkg::link_req_t req_hold_q,
  output logic req_tog_q,
  input wire logic ack_tog,
  input wire vout_prot_pkg::link_rsp_t rsp_in
);
  logic ack_s;
  logic ack_seen_q;
  logic ack_seen_d;
  logic busy_q;
  logic busy_d;
  logic req_tog_d;
  logic rsp_valid_d;
  vout_prot_pkg::link_req_t req_hold_d;
  vout_prot_pkg::link_rsp_t rsp_out_d;

  sync2 #(.W(1)) u_ack_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .din(ack_tog),
    .dout(ack_s)
  );

  // ------------------------------------------------------------
  // Handshake: one transaction in flight
  // ------------------------------------------------------------
  always_comb begin
    busy_d = busy_q;
    req_tog_d = req_tog_q;
    req_hold_d = req_hold_q;
    ack_seen_d = ack_seen_q;
    rsp_valid_d = 1'b0;
    rsp_out_d = rsp_out;
    if (!busy_q && req_valid) begin
      busy_d = 1'b1;
      req_hold_d = req_in;
      req_tog_d = ~req_tog_q;
    end else if (busy_q && (ack_s != ack_seen_q)) begin
      busy_d = 1'b0;
      ack_seen_d = ack_s;
      rsp_valid_d = 1'b1;
      rsp_out_d = rsp_in;
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      req_tog_q <= 1'b0;
      req_hold_q <= '0;
      ack_seen_q <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_out <= '0;
      req_ready <= 1'b0;
    end else begin
      busy_q <= busy_d;
      req_tog_q <= req_tog_d;
      req_hold_q <= req_hold_d;
      ack_seen_q <= ack_seen_d;
      rsp_valid <= rsp_valid_d;
      rsp_out <= rsp_out_d;
      req_ready <= ~busy_d;
    end
  end
endmodule

//--- src/vout_protection_response_limits.sv
// Output-voltage protection commands: fault action, warning limits, restart.
// Assumes a bus front end on link_clk and sense/target words on clk.
`timescale 1ns/10ps
`include "vout_prot_params.svh"
module vout_protection_response_limits (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic link_req_valid,
  input wire vout_prot_pkg::link_req_t link_req,
  output logic link_req_ready,
  output logic link_rsp_valid,
  output vout_prot_pkg::link_rsp_t link_rsp,
  input wire logic nvm_load,
  input wire logic [7:0] nvm_fault_action,
  input wire logic [15:0] nvm_high_warn,
  input wire logic [15:0] nvm_low_warn,
  input wire logic vout_mode_relative,
  input wire logic [15:0] vout_command,
  input wire logic [15:0] ov_fault_limit,
  input wire logic [15:0] vout_sense,
  input wire logic [23:0] ton_rise_cycles,
  input wire logic [23:0] ton_max_cycles,
  input wire logic ramp_done,
  input wire logic output_on_cmd,
  input wire logic clear_faults,
  output logic power_enable_q,
  output logic status_byte_ov_fault_q,
  output logic status_word_vout_q,
  output logic [7:0] status_vout_q,
  output logic [7:0] status_cml_q,
  output logic smbalert_n_q,
  output logic [7:0] fault_action_q,
  output logic [7:0] high_warn_pct_q,
  output logic [7:0] low_warn_pct_q,
  output logic [10:0] ov_fault_pct10_q,
  output logic [2:0] restart_count_q
);
  // ------------------------------------------------------------
  // Clock crossing of the command port
  // ------------------------------------------------------------
  vout_prot_pkg::link_req_t req_hold;
  vout_prot_pkg::link_rsp_t rsp_q;
  vout_prot_pkg::link_rsp_t rsp_d;
  logic req_tog;
  logic req_s;
  logic req_seen_q;
  logic req_seen_d;
  logic ack_tog_q;
  logic ack_tog_d;

  link_port u_link (
    .link_clk(link_clk),
    .reset_n(reset_n),
    .req_valid(link_req_valid),
    .req_in(link_req),
    .req_ready(link_req_ready),
    .rsp_valid(link_rsp_valid),
    .rsp_out(link_rsp),
    .req_hold_q(req_hold),
    .req_tog_q(req_tog),
    .ack_tog(ack_tog_q),
    .rsp_in(rsp_q)
  );

  sync2 #(.W(1)) u_req_sync (
    .clk(clk),
    .reset_n(reset_n),
    .din(req_tog),
    .dout(req_s)
  );

  // ------------------------------------------------------------
  // Limit mapping to hardware percentages
  // ------------------------------------------------------------
  logic [31:0] den;
  logic [31:0] hi_num;
  logic [31:0] hi_pct;
  logic [31:0] lo_pct;
  logic [31:0] f_num;
  logic [31:0] f_pct10;
  logic [31:0] f_steps;
  logic [10:0] fault_pct10_d;

  always_comb begin
    den = vout_mode_relative ? `REL_DEN : {16'h0000, vout_command};
    if (den == 32'h0000_0000) begin
      den = 32'h0000_0001;
    end
    hi_num = {16'h0000, req_hold.data} * 32'h0000_0064;
    hi_pct = (hi_num + den - 32'h0000_0001) / den;
    lo_pct = hi_num / den;
    f_num = {16'h0000, ov_fault_limit} * 32'h0000_03E8;
    f_pct10 = (f_num + den - 32'h0000_0001) / den;
    f_steps = (f_pct10 + `FAULT_PCT10_STEP - 32'h0000_0001) / `FAULT_PCT10_STEP;
    f_pct10 = f_steps * `FAULT_PCT10_STEP;
    if (f_pct10 < {21'h0, `FAULT_PCT10_MIN}) begin
      fault_pct10_d = `FAULT_PCT10_MIN;
    end else if (f_pct10 > {21'h0, `FAULT_PCT10_MAX}) begin
      fault_pct10_d = `FAULT_PCT10_MAX;
    end else begin
      fault_pct10_d = f_pct10[10:0];
    end
  end

  // ------------------------------------------------------------
  // Comparisons against the target
  // ------------------------------------------------------------
  logic [31:0] sense100;
  logic ov_trip;
  logic ov_warn;
  logic uv_warn;
  logic shut;

  always_comb begin
    sense100 = {16'h0000, vout_sense} * 32'h0000_0064;
    ov_trip = power_enable_q &&
      ({16'h0000, vout_sense} * 32'h0000_03E8 >
       {16'h0000, vout_command} * {21'h0, ov_fault_pct10_q});
    ov_warn = power_enable_q &&
      (sense100 > {16'h0000, vout_command} * {24'h0, high_warn_pct_q});
    uv_warn = power_enable_q &&
      (sense100 < {16'h0000, vout_command} * {24'h0, low_warn_pct_q});
    shut = fault_action_q[`ACT_SEL_HI:`ACT_SEL_LO] != `ACT_IGNORE;
  end

  // ------------------------------------------------------------
  // Command registers and status
  // ------------------------------------------------------------
  logic [15:0] high_warn_q;
  logic [15:0] high_warn_d;
  logic [15:0] low_warn_q;
  logic [15:0] low_warn_d;
  logic [7:0] fault_action_d;
  logic [7:0] high_pct_d;
  logic [7:0] low_pct_d;
  logic [7:0] status_vout_d;
  logic [7:0] status_cml_d;
  logic sb_ov_d;
  logic sw_vout_d;
  logic bad_cmd;
  logic bad_data;
  logic take;

  always_comb begin
    fault_action_d = fault_action_q;
    high_warn_d = high_warn_q;
    low_warn_d = low_warn_q;
    high_pct_d = high_warn_pct_q;
    low_pct_d = low_warn_pct_q;
    req_seen_d = req_s;
    ack_tog_d = ack_tog_q;
    rsp_d = rsp_q;
    bad_cmd = 1'b0;
    bad_data = 1'b0;
    take = req_s != req_seen_q;
    if (nvm_load) begin
      fault_action_d = nvm_fault_action;
      high_warn_d = nvm_high_warn;
      low_warn_d = nvm_low_warn;
    end
    if (take) begin
      ack_tog_d = ~ack_tog_q;
      rsp_d = '0;
      unique case (req_hold.code)
        `CMD_OV_FAULT_ACTION: begin
          bad_cmd = req_hold.is_word;
          if (!bad_cmd && req_hold.write) begin
            if (req_hold.data[15:8] != 8'h00 ||
                req_hold.data[`ACT_SEL_HI:`ACT_SEL_LO] == `ACT_INVALID) begin
              bad_data = 1'b1;
            end else begin
              fault_action_d = req_hold.data[7:0];
            end
          end
          rsp_d.data = {8'h00, fault_action_q};
        end
        `CMD_HIGH_WARN: begin
          bad_cmd = !req_hold.is_word;
          if (!bad_cmd && req_hold.write) begin
            if (hi_pct < {24'h0, `HIGH_PCT_MIN} || hi_pct > {24'h0, `HIGH_PCT_MAX}) begin
              bad_data = 1'b1;
            end else begin
              high_warn_d = req_hold.data;
              high_pct_d = hi_pct[7:0];
            end
          end
          rsp_d.data = high_warn_q;
        end
        `CMD_LOW_WARN: begin
          bad_cmd = !req_hold.is_word;
          if (!bad_cmd && req_hold.write) begin
            if (lo_pct < {24'h0, `LOW_PCT_MIN} || lo_pct > {24'h0, `LOW_PCT_MAX}) begin
              bad_data = 1'b1;
            end else begin
              low_warn_d = req_hold.data;
              low_pct_d = lo_pct[7:0];
            end
          end
          rsp_d.data = low_warn_q;
        end
        default: begin
          bad_cmd = 1'b1;
        end
      endcase
      if (bad_cmd || req_hold.write) begin
        rsp_d.data = 16'h0000;
      end
      rsp_d.error = bad_cmd | bad_data;
    end
    // Hardware sets win over a clear in the same cycle
    status_vout_d = clear_faults ? 8'h00 : status_vout_q;
    status_cml_d = clear_faults ? 8'h00 : status_cml_q;
    sb_ov_d = clear_faults ? 1'b0 : status_byte_ov_fault_q;
    if (ov_trip) begin
      status_vout_d[`SV_OV_FAULT] = 1'b1;
      sb_ov_d = 1'b1;
    end
    if (ov_warn) begin
      status_vout_d[`SV_OV_WARN] = 1'b1;
    end
    if (uv_warn) begin
      status_vout_d[`SV_UV_WARN] = 1'b1;
    end
    if (bad_cmd) begin
      status_cml_d[`CML_BAD_CMD] = 1'b1;
    end
    if (bad_data) begin
      status_cml_d[`CML_BAD_DATA] = 1'b1;
    end
    sw_vout_d = status_vout_d != 8'h00;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_action_q <= `RST_FAULT_ACTION;
      high_warn_q <= `RST_HIGH_WARN;
      low_warn_q <= `RST_LOW_WARN;
      high_warn_pct_q <= `HIGH_PCT_MIN;
      low_warn_pct_q <= `LOW_PCT_MAX;
      ov_fault_pct10_q <= `FAULT_PCT10_MAX;
      req_seen_q <= 1'b0;
      ack_tog_q <= 1'b0;
      rsp_q <= '0;
      status_vout_q <= 8'h00;
      status_cml_q <= 8'h00;
      status_byte_ov_fault_q <= 1'b0;
      status_word_vout_q <= 1'b0;
      smbalert_n_q <= 1'b1;
    end else begin
      fault_action_q <= fault_action_d;
      high_warn_q <= high_warn_d;
      low_warn_q <= low_warn_d;
      high_warn_pct_q <= high_pct_d;
      low_warn_pct_q <= low_pct_d;
      ov_fault_pct10_q <= fault_pct10_d;
      req_seen_q <= req_seen_d;
      ack_tog_q <= ack_tog_d;
      rsp_q <= rsp_d;
      status_vout_q <= status_vout_d;
      status_cml_q <= status_cml_d;
      status_byte_ov_fault_q <= sb_ov_d;
      status_word_vout_q <= sw_vout_d;
      smbalert_n_q <= ~(sw_vout_d | sb_ov_d | (status_cml_d != 8'h00));
    end
  end

  // ------------------------------------------------------------
  // Restart sequencer
  // ------------------------------------------------------------
  vout_prot_pkg::seq_state_t state_q;
  vout_prot_pkg::seq_state_t state_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;
  logic [31:0] hiccup_cycles;
  logic [2:0] retry;
  logic [2:0] mult;
  logic [2:0] count_d;
  logic power_d;
  logic fail;

  always_comb begin
    retry = fault_action_q[`ACT_RETRY_HI:`ACT_RETRY_LO];
    mult = fault_action_q[`ACT_MULT_HI:`ACT_MULT_LO];
    if (mult == 3'h0) begin
      mult = 3'h1;
    end
    hiccup_cycles = {8'h00, ton_rise_cycles} * {29'h0, mult};
    state_d = state_q;
    timer_d = timer_q + 32'h0000_0001;
    count_d = restart_count_q;
    power_d = power_enable_q;
    fail = 1'b0;
    unique case (state_q)
      vout_prot_pkg::ST_OFF: begin
        power_d = 1'b0;
        count_d = 3'h0;
        if (output_on_cmd) begin
          state_d = vout_prot_pkg::ST_RAMP;
          timer_d = 32'h0000_0000;
          power_d = 1'b1;
        end
      end
      vout_prot_pkg::ST_RAMP: begin
        if (ov_trip && shut) begin
          fail = 1'b1;
        end else if (ton_max_cycles != `TON_MAX_DISABLED_MS && !ramp_done &&
                     timer_q >= {8'h00, ton_max_cycles}) begin
          fail = 1'b1;
        end else if (ramp_done) begin
          state_d = vout_prot_pkg::ST_CONFIRM;
          timer_d = 32'h0000_0000;
        end
      end
      vout_prot_pkg::ST_CONFIRM: begin
        if (ov_trip && shut) begin
          fail = 1'b1;
        end else if (timer_q >= {8'h00, ton_rise_cycles}) begin
          state_d = vout_prot_pkg::ST_RUN;
          count_d = 3'h0;
        end
      end
      vout_prot_pkg::ST_RUN: begin
        fail = ov_trip && shut;
      end
      vout_prot_pkg::ST_HICCUP: begin
        if (timer_q + 32'h0000_0001 >= hiccup_cycles) begin
          state_d = vout_prot_pkg::ST_RAMP;
          timer_d = 32'h0000_0000;
          power_d = 1'b1;
        end
      end
      vout_prot_pkg::ST_LATCHED: begin
        power_d = 1'b0;
      end
      default: begin
        state_d = vout_prot_pkg::ST_OFF;
        power_d = 1'b0;
      end
    endcase
    if (fail) begin
      power_d = 1'b0;
      timer_d = 32'h0000_0000;
      if (retry == `RETRY_LATCH) begin
        state_d = vout_prot_pkg::ST_LATCHED;
      end else if (retry == `RETRY_ENDLESS) begin
        state_d = vout_prot_pkg::ST_HICCUP;
      end else if (restart_count_q < retry) begin
        state_d = vout_prot_pkg::ST_HICCUP;
        count_d = restart_count_q + 3'h1;
      end else begin
        state_d = vout_prot_pkg::ST_LATCHED;
      end
    end
    if (!output_on_cmd) begin
      state_d = vout_prot_pkg::ST_OFF;
      power_d = 1'b0;
      count_d = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= vout_prot_pkg::ST_OFF;
      timer_q <= 32'h0000_0000;
      restart_count_q <= 3'h0;
      power_enable_q <= 1'b0;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      restart_count_q <= count_d;
      power_enable_q <= power_d;
    end
  end
endmodule

//--- tb/vout_prot_assertions.sv
// Checker for the output-voltage protection block, bound to its top module.
// Assumes ramp_done follows power_enable_q and ton_rise_cycles holds still.
`timescale 1ns/10ps
module vout_prot_assertions (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic link_rsp_valid,
  input wire vout_prot_pkg::link_rsp_t link_rsp,
  input wire logic output_on_cmd,
  input wire logic ramp_done,
  input wire logic [23:0] ton_rise_cycles,
  input wire logic power_enable_q,
  input wire logic status_byte_ov_fault_q,
  input wire logic status_word_vout_q,
  input wire logic [7:0] status_vout_q,
  input wire logic [7:0] status_cml_q,
  input wire logic smbalert_n_q,
  input wire logic [7:0] fault_action_q,
  input wire logic [7:0] high_warn_pct_q,
  input wire logic [7:0] low_warn_pct_q,
  input wire logic [2:0] restart_count_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Off and on time counters
  // ----------------------------------------
  int off_d, off_q, on_d, on_q, hic;
  always_comb begin
    off_d = power_enable_q ? 0 : off_q + 1;
    on_d = (power_enable_q && ramp_done) ? on_q + 1 : 0;
    hic = (fault_action_q[2:0] == 3'h0) ? 1 : int'(fault_action_q[2:0]);
    hic = hic * int'(ton_rise_cycles);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      off_q <= 0;
      on_q <= 0;
    end else begin
      off_q <= off_d;
      on_q <= on_d;
    end
  end
  sequence s_ov_set;
    $rose(status_vout_q[7]);
  endsequence
  sequence s_restart;
    $rose(power_enable_q) && restart_count_q != 3'h0;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ovf_status: assert property (s_ov_set |-> ##[0:1] status_byte_ov_fault_q && status_word_vout_q)
    else $error("fault status bits not set");
  a_ovf_alert: assert property (s_ov_set |-> ##[0:1] !smbalert_n_q)
    else $error("alert missing after fault");
  a_warn_vout: assert property ($rose(status_vout_q[6]) || $rose(status_vout_q[5])
    |-> ##[0:1] status_word_vout_q)
    else $error("word bit missing after warning");
  a_ignore_runs: assert property (power_enable_q && output_on_cmd && fault_action_q[7:6] == 2'h0
    |=> power_enable_q || fault_action_q[7:6] != 2'h0)
    else $error("power dropped while ignoring");
  a_hiccup_len: assert property (s_restart |-> off_q + 1 >= hic && off_q <= hic + 2)
    else $error("hiccup length wrong");
  a_confirm_clear: assert property (on_q == int'(ton_rise_cycles) + 4 |-> restart_count_q == 3'h0)
    else $error("restart count not cleared");
  a_high_range: assert property (high_warn_pct_q >= 8'h67 && high_warn_pct_q <= 8'h74)
    else $error("high warning percent out of range");
  a_low_range: assert property (low_warn_pct_q >= 8'h54 && low_warn_pct_q <= 8'h61)
    else $error("low warning percent out of range");
  a_error_flags: assert property (@(posedge link_clk) disable iff (!reset_n)
    link_rsp_valid && link_rsp.error |-> status_cml_q[7] || status_cml_q[6])
    else $error("error answer without status flag");
  a_rsp_pulse: assert property (@(posedge link_clk) disable iff (!reset_n)
    link_rsp_valid |=> !link_rsp_valid)
    else $error("answer longer than one cycle");
endmodule
bind vout_protection_response_limits vout_prot_assertions i_vout_prot_assertions (.*);

//--- tb/pmbus_host_model.sv
// Host model of the command bus: one transfer at a time on link_clk.
// Assumes the block's link port handshake.
`timescale 1ns/10ps
module pmbus_host_model (
  input wire logic link_clk,
  input wire logic link_req_ready,
  input wire logic link_rsp_valid,
  input wire vout_prot_pkg::link_rsp_t link_rsp,
  output logic link_req_valid,
  output vout_prot_pkg::link_req_t link_req
);
  initial begin
    link_req_valid = 1'b0;
    link_req = '0;
  end
  task automatic xfer(input vout_prot_pkg::link_req_t req, output vout_prot_pkg::link_rsp_t rsp,
                      output logic ok);
    int n;
    logic took;
    took = 1'b0;
    ok = 1'b0;
    rsp = '0;
    @(posedge link_clk);
    link_req_valid <= 1'b1;
    link_req <= req;
    for (n = 0; n < 40 && !took; n++) begin
      @(posedge link_clk);
      took = link_req_ready;
    end
    link_req_valid <= 1'b0;
    link_req <= ~req;
    for (n = 0; n < 40 && took && !ok; n++) begin
      @(posedge link_clk);
      ok = link_rsp_valid;
      rsp = link_rsp;
    end
  endtask
endmodule

//--- tb/tb_vout_protection_response_limits.sv
// Testbench: command table, then restart, warning and status scenarios.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
`include "vout_prot_params.svh"
module tb_vout_protection_response_limits;
  typedef struct packed {
    logic wr;
    logic word;
    logic [7:0] code;
    logic [15:0] data;
    logic err;
    logic [15:0] exp;
  } row_t;
  typedef struct packed {
    logic [7:0] act;
    int lo;
    int hi;
  } seq_t;
  logic clk, reset_n, link_clk, link_req_valid, link_req_ready, link_rsp_valid, ok, was;
  vout_prot_pkg::link_req_t link_req;
  vout_prot_pkg::link_rsp_t link_rsp, rsp;
  logic nvm_load, vout_mode_relative, ramp_done, output_on_cmd, clear_faults;
  logic [15:0] vout_command, ov_fault_limit, vout_sense;
  logic [23:0] ton_rise_cycles, ton_max_cycles;
  logic power_enable_q, status_byte_ov_fault_q, status_word_vout_q, smbalert_n_q;
  logic [7:0] status_vout_q, status_cml_q, fault_action_q, high_warn_pct_q, low_warn_pct_q;
  logic [10:0] ov_fault_pct10_q;
  logic [2:0] restart_count_q;
  int err_count, checked, falls;
  row_t rows [17] = '{
    '{1'b1, 1'b0, 8'h41, 16'h0092, 1'b0, 16'h0092},
    '{1'b1, 1'b0, 8'h41, 16'h00C0, 1'b1, 16'h0092},
    '{1'b1, 1'b0, 8'h41, 16'h0192, 1'b1, 16'h0092},
    '{1'b1, 1'b1, 8'h41, 16'h0040, 1'b1, 16'h0092},
    '{1'b0, 1'b0, 8'h41, 16'h0000, 1'b0, 16'h0092},
    '{1'b1, 1'b1, 8'h42, 16'h00CE, 1'b0, 16'h0067},
    '{1'b1, 1'b1, 8'h42, 16'h00CF, 1'b0, 16'h0068},
    '{1'b1, 1'b1, 8'h42, 16'h00E8, 1'b0, 16'h0074},
    '{1'b1, 1'b1, 8'h42, 16'h00E9, 1'b1, 16'h0074},
    '{1'b1, 1'b0, 8'h42, 16'h00CE, 1'b1, 16'h0074},
    '{1'b0, 1'b1, 8'h42, 16'h0000, 1'b0, 16'h00E8},
    '{1'b1, 1'b1, 8'h43, 16'h00A8, 1'b0, 16'h0054},
    '{1'b1, 1'b1, 8'h43, 16'h00BF, 1'b0, 16'h005F},
    '{1'b1, 1'b1, 8'h43, 16'h00C3, 1'b0, 16'h0061},
    '{1'b1, 1'b1, 8'h43, 16'h00A7, 1'b1, 16'h0061},
    '{1'b0, 1'b1, 8'h43, 16'h0000, 1'b0, 16'h00C3},
    '{1'b1, 1'b1, 8'h44, 16'h0000, 1'b1, 16'h0000}
  };
  seq_t seqs [4] = '{'{8'h00, 0, 0}, '{8'h40, 1, 1}, '{8'h92, 3, 3}, '{8'h78, 5, 40}};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge clk) ramp_done <= power_enable_q;
  vout_protection_response_limits i_vout_protection_response_limits (
    .nvm_fault_action(8'h49), .nvm_high_warn(16'h0214), .nvm_low_warn(16'h01D7), .*
  );
  pmbus_host_model i_pmbus_host_model (.*);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic word, input logic [7:0] code,
                     input logic [15:0] data);
    i_pmbus_host_model.xfer({wr, word, code, data}, rsp, ok);
    chk({15'h0, ok}, 16'h0001);
    if (ok !== 1'b1) end_of_test();
  endtask
  task automatic wait_on();
    int n;
    for (n = 0; n < 60 && power_enable_q !== 1'b1; n++) @(posedge clk);
    chk({15'h0, power_enable_q}, 16'h0001);
    if (power_enable_q !== 1'b1) end_of_test();
  endtask
  task automatic clr();
    @(posedge clk) clear_faults <= 1'b1;
    @(posedge clk) clear_faults <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  function automatic logic [15:0] reg_of(input logic [7:0] code);
    case (code)
      8'h41: return {8'h00, fault_action_q};
      8'h42: return {8'h00, high_warn_pct_q};
      8'h43: return {8'h00, low_warn_pct_q};
      default: return 16'h0000;
    endcase
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    nvm_load = 1'b0;
    vout_mode_relative = 1'b0;
    output_on_cmd = 1'b0;
    ton_max_cycles = 24'h00_0020;
    clear_faults = 1'b0;
    vout_command = 16'h00C8;
    ov_fault_limit = 16'h00D3;
    vout_sense = 16'h00C8;
    ton_rise_cycles = 24'h00_0008;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({8'h00, fault_action_q}, {8'h00, `RST_FAULT_ACTION});
    chk({high_warn_pct_q, low_warn_pct_q}, {`HIGH_PCT_MIN, `LOW_PCT_MAX});
    @(posedge clk) nvm_load <= 1'b1;
    @(posedge clk) nvm_load <= 1'b0;
    repeat (2) @(posedge clk);
    chk({8'h00, fault_action_q}, 16'h0049);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].word, rows[i].code, rows[i].data);
      chk({15'h0, rsp.error}, {15'h0, rows[i].err});
      chk(rows[i].wr ? reg_of(rows[i].code) : rsp.data, rows[i].exp);
    end
    chk({7'h0, smbalert_n_q, status_cml_q}, 16'h00C0);
    clr();
    chk({7'h0, smbalert_n_q, status_cml_q}, 16'h0100);
    @(posedge clk) vout_command <= 16'h0064;
    repeat (3) @(posedge clk);
    bus(1'b0, 1'b1, 8'h42, 16'h0000);
    chk({rsp.data[7:0], high_warn_pct_q}, 16'hE874);
    @(posedge clk) vout_command <= 16'h00C8;
    vout_mode_relative <= 1'b1;
    bus(1'b1, 1'b1, 8'h42, 16'h0214);
    chk({8'h00, high_warn_pct_q}, 16'h0068);
    @(posedge clk) vout_mode_relative <= 1'b0;
    repeat (3) @(posedge clk);
    chk({5'h00, ov_fault_pct10_q}, 16'h0433);
    foreach (seqs[i]) begin
      output_on_cmd <= 1'b0;
      vout_sense <= 16'h00C8;
      repeat (4) @(posedge clk);
      bus(1'b1, 1'b0, 8'h41, {8'h00, seqs[i].act});
      @(posedge clk) output_on_cmd <= 1'b1;
      wait_on();
      repeat (20) @(posedge clk);
      chk({13'h0, restart_count_q}, 16'h0000);
      vout_sense <= 16'h0104;
      falls = 0;
      was = 1'b1;
      repeat (150) begin
        @(posedge clk);
        if (power_enable_q === 1'b0 && was) falls++;
        was = power_enable_q;
      end
      chk({15'h0, falls >= seqs[i].lo && falls <= seqs[i].hi}, 16'h0001);
    end
    vout_sense <= 16'h00C8;
    repeat (60) @(posedge clk);
    chk({12'h0, power_enable_q, restart_count_q}, 16'h0008);
    chk({12'h0, status_byte_ov_fault_q, status_word_vout_q, status_vout_q[7], smbalert_n_q},
        16'h000E);
    clr();
    chk({7'h0, smbalert_n_q, status_vout_q}, 16'h0100);
    ov_fault_limit <= 16'h0118;
    repeat (3) @(posedge clk);
    vout_sense <= 16'h00F0;
    repeat (4) @(posedge clk);
    chk({7'h0, status_word_vout_q, status_vout_q}, 16'h0140);
    vout_sense <= 16'h00C8;
    clr();
    vout_sense <= 16'h0096;
    repeat (4) @(posedge clk);
    chk({7'h0, status_word_vout_q, status_vout_q}, 16'h0120);
    end_of_test();
  end
endmodule
